// ### bench/rfppc_stage.sv
// Purpose: Behavioural power stage feeding output level back
// Assumes: Same clock as the block
// Notes: A nonzero forced level stands for a fault
`timescale 1ns/1ps
module rfppc_stage (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Stage control
  input wire run,
  input wire [7:0] fault_pct,
  // Measured output
  output reg [7:0] vout_pct,
  output reg ramp_done
);
  // Ramps two percent a cycle up to nominal
  always @(posedge clk) begin
    if (rst || !run) begin
      vout_pct <= 8'h00;
      ramp_done <= 1'b0;
    end else if (fault_pct != 8'h00) begin
      vout_pct <= fault_pct;
    end else if (vout_pct < 8'd100) begin
      vout_pct <= vout_pct + 8'd2;
    end else begin
      ramp_done <= 1'b1;
    end
  end
endmodule // rfppc_stage

// ### bench/rfppc_top_chk.sv
// Purpose: Port-level properties of the fault and power-good block
// Assumes: Bound to rfppc_top; one clock domain
// Notes: Reset disables all but the reset property
`timescale 1ns/1ps
module rfppc_top_chk (
  // Clock and reset
  input wire CLK,
  input wire RST,
  // Register bus
  input wire [7:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_READDATA,
  input wire AVS_WAITREQUEST,
  // Power stage and pins
  input wire [7:0] VOUT_PCT,
  input wire OUTPUT_RUN,
  input wire POWER_GOOD_OUT,
  input wire POWER_GOOD_OE,
  input wire PWM_TRIGGER
);
  a_bus_answer: assert property (@(posedge CLK) disable iff (RST)
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("bus request not answered");
  a_wait_pulse: assert property (@(posedge CLK) disable iff (RST)
    $fell(AVS_WAITREQUEST) |=> AVS_WAITREQUEST)
    else $error("waitrequest low too long");
  a_unmapped_zero: assert property (@(posedge CLK) disable iff (RST)
    AVS_READ && !AVS_WAITREQUEST && (AVS_ADDRESS > 8'h1c ||
    AVS_ADDRESS[1:0] != 2'h0) |-> AVS_READDATA == 32'h0)
    else $error("unmapped read not zero");
  a_ov_shutdown: assert property (
    @(posedge CLK) disable iff (RST)
    OUTPUT_RUN && VOUT_PCT > 8'd130 |-> ##[1:3] !OUTPUT_RUN)
    else $error("over-voltage did not stop output");
  a_pg_off_low: assert property (
    @(posedge CLK) disable iff (RST)
    !OUTPUT_RUN [*3] |-> !POWER_GOOD_OUT)
    else $error("power good high while output off");
  a_od_drive: assert property (
    @(posedge CLK) disable iff (RST)
    !POWER_GOOD_OE |-> !POWER_GOOD_OUT)
    else $error("power good driven high while released");
  a_pwm_pulse: assert property (
    @(posedge CLK) disable iff (RST)
    PWM_TRIGGER |=> !PWM_TRIGGER)
    else $error("pwm trigger wider than one cycle");
  a_reset_idle: assert property (@(posedge CLK)
    RST |=> AVS_WAITREQUEST && !OUTPUT_RUN && !PWM_TRIGGER &&
    !POWER_GOOD_OUT)
    else $error("outputs not idle in reset");
endmodule // rfppc_top_chk

bind rfppc_top rfppc_top_chk rfppc_top_chk_inst (
  .CLK(CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .VOUT_PCT(VOUT_PCT),
  .OUTPUT_RUN(OUTPUT_RUN), .POWER_GOOD_OUT(POWER_GOOD_OUT),
  .POWER_GOOD_OE(POWER_GOOD_OE), .PWM_TRIGGER(PWM_TRIGGER)
);

// ### bench/rfppc_top_tb.sv
// Purpose: Self-checking bench of the fault and power-good block
// Assumes: Short hiccup interval; dual-output strap codes
// Notes: Straps and address are random from a fixed seed
`timescale 1ns/1ps
`define CHK(a, b, m) begin checks = checks + 1; if ((a) !== (b)) begin \
  err_count = err_count + 1; $display("wrong value at %0t: %s", $time, m); \
  end end
module rfppc_top_tb;
  localparam HIC = 50;
  reg CLK, RST, rd, wr, sync_in;
  reg [7:0] addr, fault;
  reg [31:0] wdata, rdata;
  reg [8:0] iout;
  reg [4:0] cfg;
  reg [2:0] fstrap;
  reg [6:0] baddr;
  wire [31:0] rd_data;
  wire wait_req, run, ramp_done, pg, pg_oe, sync_oe, pwm, sync_out;
  wire [7:0] vout;
  integer seed, err_count, checks, n, i;
  integer cyc = 0;

  rfppc_top #(.HICCUP_CYCLES(HIC)) rfppc_top_inst (
    .CLK(CLK), .RST(RST), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hf),
    .AVS_READDATA(rd_data), .AVS_WAITREQUEST(wait_req),
    .VOUT_PCT(vout), .IOUT_AMP(iout), .RAMP_DONE(ramp_done),
    .OUTPUT_RUN(run), .CFG_STRAP(cfg), .FREQ_STRAP(fstrap),
    .BUS_ADDR(baddr), .POWER_GOOD_OUT(pg), .POWER_GOOD_OE(pg_oe),
    .SYNC_IN(sync_in), .SYNC_OUT(sync_out), .SYNC_OE(sync_oe),
    .PWM_TRIGGER(pwm));
  rfppc_stage rfppc_stage_inst (.clk(CLK), .rst(RST), .run(run),
    .fault_pct(fault), .vout_pct(vout), .ramp_done(ramp_done));

  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      stop_test;
    end
  end

  function [11:0] khz(input [2:0] c);
    case (c)
      0: khz = 400; 1: khz = 432; 2: khz = 457; 3: khz = 533;
      4: khz = 571; 5: khz = 615; 6: khz = 727; default: khz = 800;
    endcase
  endfunction
  // Page-1 limit, reverse limit, page-0 limit
  function [21:0] ilim(input [4:0] c);
    case (c)
      0: ilim = {6'd35, 8'd10, 8'd35}; 1: ilim = {6'd45, 8'd10, 8'd45};
      2: ilim = {6'd55, 8'd10, 8'd55}; 3: ilim = {6'd60, 8'd10, 8'd60};
      4: ilim = {6'd35, 8'd10, 8'd45}; 5: ilim = {6'd35, 8'd10, 8'd55};
      6: ilim = {6'd45, 8'd10, 8'd55}; 7: ilim = {6'd45, 8'd10, 8'd35};
      8: ilim = {6'd55, 8'd10, 8'd35}; default: ilim = {6'd55, 8'd10, 8'd45};
    endcase
  endfunction

  task bus(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge CLK);
      rd <= !w;
      wr <= w;
      addr <= a;
      wdata <= d;
      @(posedge CLK);
      while (wait_req !== 1'b0) @(posedge CLK);
      rdata = rd_data;
      rd <= 1'b0;
      wr <= 1'b0;
    end
  endtask
  task rdc(input [7:0] a, input [31:0] e, input [31:0] m);
    begin
      bus(1'b0, a, 32'h0);
      `CHK(rdata & m, e, "register read")
    end
  endtask
  task wrun(input v, input integer lim);
    begin
      n = 0;
      while (run !== v && n < lim) begin
        @(posedge CLK);
        n = n + 1;
      end
      `CHK(run, v, "output run state")
    end
  endtask
  // Waits for a finished ramp with normal load current
  task up;
    begin
      wrun(1'b1, HIC + 20);
      iout <= {4'h0, 5'($random(seed))};
      while (ramp_done !== 1'b1 && n < 400) begin
        @(posedge CLK);
        n = n + 1;
      end
    end
  endtask
  task stop_test;
    begin
      if (err_count == 0 && checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  initial begin
    seed = 20;
    err_count = 0;
    checks = 0;
    RST = 1'b1;
    {rd, wr, sync_in, addr, fault, wdata, iout} = 0;
    fstrap = $random(seed);
    // lone module: no four-phase partner address to pair with
    baddr = $random(seed);
    cfg = 5'($unsigned($random(seed)) % 10);
    repeat (8) @(posedge CLK);
    RST <= 1'b0;
    repeat (6) @(posedge CLK);
    `CHK(sync_oe, 1'b0, "sync pin driven by default")
    rdc(8'h04, 32'h555a556e, 32'hffffffff);
    rdc(8'h08, 32'h1, 32'h7);
    rdc(8'h10, 32'ha, 32'hffff);
    rdc(8'h18, {28'h0, baddr[3:0]}, 32'hff);
    rdc(8'h20, 32'h0, 32'hffffffff);
    rdc(8'h0c, {10'h0, ilim(cfg)}, 32'h3fffff);
    rdc(8'h1c, {4'h0, khz(fstrap), 16'h1000}, 32'h0fff1e00);
    bus(1'b1, 8'h10, 32'h1);
    bus(1'b1, 8'h00, 32'h1);
    up;
    repeat (20) @(posedge CLK);
    `CHK(pg, 1'b0, "power good during delay")
    repeat (20) @(posedge CLK);
    `CHK(pg, 1'b1, "power good after delay")
    fault <= 8'd140;
    wrun(1'b0, 5);
    fault <= 8'h00;
    repeat (3) @(posedge CLK);
    `CHK(pg, 1'b0, "power good in fault")
    wrun(1'b1, HIC + 20);
    `CHK(n >= HIC - 5, 1'b1, "restart too early")
    bus(1'b1, 8'h08, 32'h0);
    // Over-voltage, under-voltage, over-current, reverse current
    for (i = 0; i < 4; i = i + 1) begin
      up;
      if (i < 2)
        fault <= (i == 0) ? 8'd140 : 8'd80;
      else
        iout <= (i == 2) ? 9'd200 : 9'h19c;
      wrun(1'b0, 40);
      fault <= 8'h00;
      iout <= 9'h000;
      repeat (3 * HIC) @(posedge CLK);
      `CHK(run, 1'b0, "latched output restarted")
      bus(1'b1, 8'h00, 32'h3);
      wrun(1'b1, 10);
    end
    up;
    repeat (40) @(posedge CLK);
    bus(1'b1, 8'h00, 32'h15);
    repeat (3) @(posedge CLK);
    `CHK({pg_oe, pg}, 2'b00, "open-drain power good")
    `CHK(sync_oe, 1'b1, "sync output mode")
    // Internal clock on the pin: high about half of each period
    n = 0;
    repeat (70) begin
      @(posedge CLK);
      n = n + sync_out;
    end
    `CHK(n >= 20 && n <= 50, 1'b1, "sync output clock")
    bus(1'b1, 8'h14, 32'd500);
    bus(1'b1, 8'h18, 32'h84);
    bus(1'b1, 8'h00, 32'h2d);
    rdc(8'h1c, {4'h0, 12'd500, 16'h0}, 32'h0fff0000);
    // Let pulses started by the internal clock run out first
    repeat (70) @(posedge CLK);
    sync_in <= 1'b1;
    n = 0;
    while (pwm !== 1'b1 && n < 200) begin
      @(posedge CLK);
      n = n + 1;
    end
    `CHK(n >= 26 && n <= 32, 1'b1, "phase offset")
    // Restart with single-output, then four-phase master straps
    for (i = 0; i < 2; i = i + 1) begin
      RST <= 1'b1;
      cfg <= (i == 0) ? 5'h0a : 5'h0d;
      repeat (8) @(posedge CLK);
      RST <= 1'b0;
      repeat (6) @(posedge CLK);
      if (i == 0)
        rdc(8'h1c, {3'h0, khz(fstrap), 17'h01200}, 32'h0fff1e00);
      else
        rdc(8'h1c, {4'h0, khz(fstrap), 16'h1c00}, 32'h0fff1e00);
      bus(1'b1, 8'h00, 32'h1);
      up;
      fault <= 8'd140;
      wrun(1'b0, 5);
      fault <= 8'h00;
      repeat (HIC + 20) @(posedge CLK);
      `CHK(run, i == 0, "restart after over-voltage")
    end
    stop_test;
  end
endmodule // rfppc_top_tb

// ### common/rfppc_defs.vh
// Purpose: Constants of the regulator fault, power-good and phase block
// Assumes: Included by bare name from the design files
// Notes: Offsets are byte addresses on the register bus
`ifndef RFPPC_DEFS_VH
`define RFPPC_DEFS_VH

// Clock and timing
`define RFPPC_CLK_KHZ 25000
`define RFPPC_US_CYC (`RFPPC_CLK_KHZ / 1000)
`define RFPPC_HICCUP_MS 40
`define RFPPC_HICCUP_CYC (`RFPPC_HICCUP_MS * `RFPPC_CLK_KHZ)
`define RFPPC_FILT_CYC 16
`define RFPPC_STRAP_CYC 3

// Register byte offsets
`define RFPPC_REG_CTRL 8'h00
`define RFPPC_REG_VLIM 8'h04
`define RFPPC_REG_RESP 8'h08
`define RFPPC_REG_ILIM 8'h0c
`define RFPPC_REG_PGDLY 8'h10
`define RFPPC_REG_FREQ 8'h14
`define RFPPC_REG_INTLV 8'h18
`define RFPPC_REG_STAT 8'h1c

// Control fields
`define RFPPC_CTRL_EN 0
`define RFPPC_CTRL_CLR 1
`define RFPPC_CTRL_OD 2
`define RFPPC_CTRL_SYNC_LO 3
`define RFPPC_CTRL_SYNC_HI 4
`define RFPPC_CTRL_FOVR 5

// Response fields, set bit selects restart mode in dual and single modes
`define RFPPC_RESP_VOLT 0
`define RFPPC_RESP_OC 1
`define RFPPC_RESP_RC 2

// Reset values
`define RFPPC_CTRL_RST 32'h0000_0000
`define RFPPC_VLIM_RST 32'h555a_556e
`define RFPPC_RESP_RST 3'h1
`define RFPPC_RC_LIM_RST 8'h0a
`define RFPPC_PGDLY_RST 16'h000a
`define RFPPC_FREQ_RST 11'h000

// Sync pin modes
`define RFPPC_SYNC_INT 2'h0
`define RFPPC_SYNC_IN 2'h1
`define RFPPC_SYNC_OUT 2'h2

// Circuit modes from the configuration strap
`define RFPPC_MODE_DUAL 2'h0
`define RFPPC_MODE_SINGLE 2'h1
`define RFPPC_MODE_MASTER 2'h2
`define RFPPC_MODE_SLAVE 2'h3

`endif

// ### logic/rfppc_top.v
// Purpose: Fault response, power-good, strap decode and phase spreading
// Assumes: Measurements come from logic on CLK; straps and sync are pins
// Notes: One regulated channel; percent values are of the nominal output
`timescale 1ns/1ps
`include "rfppc_defs.vh"

module rfppc_top #(
  parameter HICCUP_CYCLES = `RFPPC_HICCUP_CYC,
  parameter PERIOD_W = 16
) (
  // Clock and reset
  input wire CLK,
  input wire RST,
  // Register bus
  input wire [7:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  input wire [3:0] AVS_BYTEENABLE,
  output reg [31:0] AVS_READDATA,
  output reg AVS_WAITREQUEST,
  // Measurements and power stage
  input wire [7:0] VOUT_PCT,
  input wire [8:0] IOUT_AMP,
  input wire RAMP_DONE,
  output reg OUTPUT_RUN,
  // Strap pins
  input wire [4:0] CFG_STRAP,
  input wire [2:0] FREQ_STRAP,
  input wire [6:0] BUS_ADDR,
  // Power-good pin
  output reg POWER_GOOD_OUT,
  output reg POWER_GOOD_OE,
  // Sync pin and PWM timing
  input wire SYNC_IN,
  output reg SYNC_OUT,
  output reg SYNC_OE,
  output reg PWM_TRIGGER
);

  localparam ST_OFF = 3'h0;
  localparam ST_RAMP = 3'h1;
  localparam ST_ON = 3'h2;
  localparam ST_LATCH = 3'h3;
  localparam ST_HICCUP = 3'h4;

  // Strap decode: {mode, limit page 1, limit page 0}
  function [13:0] cfg_decode;
    input [4:0] code;
    begin
      case (code)
        5'h00: cfg_decode = {`RFPPC_MODE_DUAL, 6'h23, 6'h23};
        5'h01: cfg_decode = {`RFPPC_MODE_DUAL, 6'h2d, 6'h2d};
        5'h02: cfg_decode = {`RFPPC_MODE_DUAL, 6'h37, 6'h37};
        5'h03: cfg_decode = {`RFPPC_MODE_DUAL, 6'h3c, 6'h3c};
        5'h04: cfg_decode = {`RFPPC_MODE_DUAL, 6'h23, 6'h2d};
        5'h05: cfg_decode = {`RFPPC_MODE_DUAL, 6'h23, 6'h37};
        5'h06: cfg_decode = {`RFPPC_MODE_DUAL, 6'h2d, 6'h37};
        5'h07: cfg_decode = {`RFPPC_MODE_DUAL, 6'h2d, 6'h23};
        5'h08: cfg_decode = {`RFPPC_MODE_DUAL, 6'h37, 6'h23};
        5'h09: cfg_decode = {`RFPPC_MODE_DUAL, 6'h37, 6'h2d};
        5'h0a: cfg_decode = {`RFPPC_MODE_SINGLE, 6'h23, 6'h23};
        5'h0b: cfg_decode = {`RFPPC_MODE_SINGLE, 6'h2d, 6'h2d};
        5'h0c: cfg_decode = {`RFPPC_MODE_SINGLE, 6'h37, 6'h37};
        5'h0d: cfg_decode = {`RFPPC_MODE_MASTER, 6'h23, 6'h23};
        5'h0e: cfg_decode = {`RFPPC_MODE_SLAVE, 6'h23, 6'h23};
        5'h0f: cfg_decode = {`RFPPC_MODE_MASTER, 6'h2d, 6'h2d};
        5'h10: cfg_decode = {`RFPPC_MODE_SLAVE, 6'h2d, 6'h2d};
        5'h11: cfg_decode = {`RFPPC_MODE_MASTER, 6'h37, 6'h37};
        5'h12: cfg_decode = {`RFPPC_MODE_SLAVE, 6'h37, 6'h37};
        5'h13: cfg_decode = {`RFPPC_MODE_SINGLE, 6'h14, 6'h14};
        5'h15: cfg_decode = {`RFPPC_MODE_DUAL, 6'h23, 6'h23};
        default: cfg_decode = {`RFPPC_MODE_DUAL, 6'h14, 6'h14};
      endcase
    end
  endfunction

  // Strap code to switching frequency in kHz
  function [10:0] freq_decode;
    input [2:0] code;
    begin
      case (code)
        3'h1: freq_decode = 11'd432;
        3'h2: freq_decode = 11'd457;
        3'h3: freq_decode = 11'd533;
        3'h4: freq_decode = 11'd571;
        3'h5: freq_decode = 11'd615;
        3'h6: freq_decode = 11'd727;
        3'h7: freq_decode = 11'd800;
        default: freq_decode = 11'd400;
      endcase
    end
  endfunction

  // Byte-lane merge of a bus write
  function [31:0] be_merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] be;
    integer i;
    begin
      be_merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) begin
          be_merge[i*8 +: 8] = data[i*8 +: 8];
        end
      end
    end
  endfunction

  // Pin synchronisers
  reg [4:0] cfg_s1, cfg_s2;
  reg [2:0] frq_s1, frq_s2;
  reg [6:0] adr_s1, adr_s2;
  reg sync_s1, sync_s2, sync_q;
  // Strap capture
  reg [1:0] strap_cnt;
  reg strap_ready;
  reg [1:0] circuit_mode;
  reg [5:0] oc_lim_b;
  reg [10:0] strap_freq;
  // Registers
  reg [31:0] ctrl;
  reg [31:0] vlim;
  reg [2:0] resp;
  reg [7:0] oc_lim;
  reg [7:0] rc_lim;
  reg [15:0] pg_delay;
  reg [10:0] freq_reg;
  reg [3:0] order;
  reg [3:0] group;
  reg clr_pulse;
  // Fault machine
  reg [2:0] state, next_state;
  reg en_q;
  reg [31:0] hic_cnt;
  reg f_ov, f_uv, f_oc, f_rc;
  reg [4:0] oc_cnt, rc_cnt;
  // Power-good
  reg pg;
  reg [23:0] pg_cnt;
  // Phase timing
  reg [PERIOD_W-1:0] int_cnt;
  reg [PERIOD_W-1:0] ph_cnt;
  reg ph_run;
  reg [31:0] rd_mux;
  wire [13:0] cfg_code = cfg_decode(cfg_s2);
  wire [31:0] pgdly_wr = be_merge({16'h0000, pg_delay}, AVS_WRITEDATA,
    AVS_BYTEENABLE);
  wire [31:0] freq_wr = be_merge({21'h000000, freq_reg}, AVS_WRITEDATA,
    AVS_BYTEENABLE);

  wire wr_en = AVS_WRITE && !AVS_WAITREQUEST;
  wire [7:0] ov_lim = vlim[7:0];
  wire [7:0] uv_lim = vlim[15:8];
  wire [7:0] pg_on = vlim[23:16];
  wire [7:0] pg_off = vlim[31:24];
  wire enable = ctrl[`RFPPC_CTRL_EN] && strap_ready;
  wire en_rise = enable && !en_q;
  wire [1:0] sync_mode = ctrl[`RFPPC_CTRL_SYNC_HI:`RFPPC_CTRL_SYNC_LO];
  wire running = (state == ST_RAMP) || (state == ST_ON);
  wire sharing = circuit_mode[1];
  wire droop = circuit_mode[1];
  wire [8:0] iout_mag = IOUT_AMP[8] ? (~IOUT_AMP + 9'h001) : IOUT_AMP;
  wire oc_now = !IOUT_AMP[8] && (iout_mag > {1'b0, oc_lim});
  wire rc_now = IOUT_AMP[8] && (iout_mag > {1'b0, rc_lim});

  wire ov_det = running && (VOUT_PCT > ov_lim);
  wire uv_det = (state == ST_ON) && (VOUT_PCT < uv_lim);
  wire oc_det = (state == ST_ON) && (oc_cnt == `RFPPC_FILT_CYC);
  wire rc_det = (state == ST_ON) && (rc_cnt == `RFPPC_FILT_CYC);
  wire any_fault = ov_det || uv_det || oc_det || rc_det;

  // one choice for both voltage faults
  // current faults latch unless restart is chosen outside master and slave modes
  wire want_hiccup = !sharing &&
    (!(ov_det || uv_det) || resp[`RFPPC_RESP_VOLT]) &&
    (!oc_det || resp[`RFPPC_RESP_OC]) &&
    (!rc_det || resp[`RFPPC_RESP_RC]);

  wire [10:0] freq = (ctrl[`RFPPC_CTRL_FOVR] && freq_reg != 11'h000) ?
    freq_reg : strap_freq;
  wire [11:0] eff_freq = (circuit_mode == `RFPPC_MODE_SINGLE) ?
    {freq, 1'b0} : {1'b0, freq};
  wire [31:0] period_full = `RFPPC_CLK_KHZ / freq;
  wire [PERIOD_W-1:0] period = period_full[PERIOD_W-1:0];
  wire [4:0] group_n = (group == 4'h0) ? 5'h10 : {1'b0, group};
  // offset is period times order over group
  wire [PERIOD_W+3:0] ph_prod = period * order;
  wire [PERIOD_W+3:0] ph_div = ph_prod / group_n;
  wire [PERIOD_W-1:0] ph_off = ph_div[PERIOD_W-1:0];
  wire [31:0] pg_delay_full = pg_delay * `RFPPC_US_CYC;
  wire [23:0] pg_delay_cyc = pg_delay_full[23:0];

  wire int_edge = (int_cnt == period - 1'b1);
  wire ext_edge = sync_s2 && !sync_q;
  // only input mode listens to the pin
  wire ref_edge = (sync_mode == `RFPPC_SYNC_IN) ? ext_edge : int_edge;

  // Pin synchronisers and strap capture
  always @(posedge CLK) begin
    if (RST) begin
      cfg_s1 <= 5'h00;
      cfg_s2 <= 5'h00;
      frq_s1 <= 3'h0;
      frq_s2 <= 3'h0;
      adr_s1 <= 7'h00;
      adr_s2 <= 7'h00;
      sync_s1 <= 1'b0;
      sync_s2 <= 1'b0;
      sync_q <= 1'b0;
      strap_cnt <= 2'h0;
      strap_ready <= 1'b0;
      circuit_mode <= `RFPPC_MODE_DUAL;
      oc_lim_b <= 6'h00;
      strap_freq <= 11'd400;
    end else begin
      cfg_s1 <= CFG_STRAP;
      cfg_s2 <= cfg_s1;
      frq_s1 <= FREQ_STRAP;
      frq_s2 <= frq_s1;
      adr_s1 <= BUS_ADDR;
      adr_s2 <= adr_s1;
      sync_s1 <= SYNC_IN;
      sync_s2 <= sync_s1;
      sync_q <= sync_s2;
      if (!strap_ready) begin
        strap_cnt <= strap_cnt + 2'h1;
        if (strap_cnt == `RFPPC_STRAP_CYC) begin
          strap_ready <= 1'b1;
          circuit_mode <= cfg_code[13:12];
          oc_lim_b <= cfg_code[11:6];
          strap_freq <= freq_decode(frq_s2);
        end
      end
    end
  end

  // Register file
  always @(posedge CLK) begin
    if (RST) begin
      ctrl <= `RFPPC_CTRL_RST;
      vlim <= `RFPPC_VLIM_RST;
      resp <= `RFPPC_RESP_RST;
      oc_lim <= 8'h00;
      rc_lim <= `RFPPC_RC_LIM_RST;
      pg_delay <= `RFPPC_PGDLY_RST;
      freq_reg <= `RFPPC_FREQ_RST;
      order <= 4'h0;
      group <= 4'h0;
      clr_pulse <= 1'b0;
    end else begin
      clr_pulse <= 1'b0;
      if (!strap_ready && strap_cnt == `RFPPC_STRAP_CYC) begin
        oc_lim <= {2'h0, cfg_code[5:0]};
        order <= adr_s2[3:0];
        group <= 4'h0;
      end else if (wr_en) begin
        case (AVS_ADDRESS)
          `RFPPC_REG_CTRL: begin
            ctrl <= be_merge(ctrl, AVS_WRITEDATA, AVS_BYTEENABLE) &
              32'h0000_003d;
            clr_pulse <= AVS_BYTEENABLE[0] &&
              AVS_WRITEDATA[`RFPPC_CTRL_CLR];
          end
          `RFPPC_REG_VLIM:
            vlim <= be_merge(vlim, AVS_WRITEDATA, AVS_BYTEENABLE);
          `RFPPC_REG_RESP:
            if (AVS_BYTEENABLE[0]) begin
              resp <= AVS_WRITEDATA[2:0];
            end
          `RFPPC_REG_ILIM: begin
            if (AVS_BYTEENABLE[0]) begin
              oc_lim <= AVS_WRITEDATA[7:0];
            end
            if (AVS_BYTEENABLE[1]) begin
              rc_lim <= AVS_WRITEDATA[15:8];
            end
          end
          `RFPPC_REG_PGDLY:
            pg_delay <= pgdly_wr[15:0];
          `RFPPC_REG_FREQ:
            freq_reg <= freq_wr[10:0];
          `RFPPC_REG_INTLV:
            if (AVS_BYTEENABLE[0]) begin
              order <= AVS_WRITEDATA[3:0];
              group <= AVS_WRITEDATA[7:4];
            end
          default: begin
          end
        endcase
      end
    end
  end

  // Read data and status
  always @* begin
    case (AVS_ADDRESS)
      `RFPPC_REG_CTRL: rd_mux = ctrl;
      `RFPPC_REG_VLIM: rd_mux = vlim;
      `RFPPC_REG_RESP: rd_mux = {29'h00000000, resp};
      `RFPPC_REG_ILIM: rd_mux = {10'h000, oc_lim_b, rc_lim, oc_lim};
      `RFPPC_REG_PGDLY: rd_mux = {16'h0000, pg_delay};
      `RFPPC_REG_FREQ: rd_mux = {21'h000000, freq_reg};
      `RFPPC_REG_INTLV: rd_mux = {24'h000000, group, order};
      `RFPPC_REG_STAT: rd_mux = {4'h0, eff_freq, 3'h0, strap_ready, droop,
        circuit_mode, state == ST_HICCUP, state == ST_LATCH,
        state == ST_RAMP, running, pg, f_rc, f_oc, f_uv, f_ov};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Bus handshake: one wait cycle, then accept
  always @(posedge CLK) begin
    if (RST) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= 32'h0000_0000;
    end else if (!AVS_WAITREQUEST) begin
      AVS_WAITREQUEST <= 1'b1;
    end else if (AVS_READ || AVS_WRITE) begin
      AVS_WAITREQUEST <= 1'b0;
      if (AVS_READ) begin
        AVS_READDATA <= rd_mux;
      end
    end
  end

  // Fault state transitions
  always @* begin
    next_state = state;
    case (state)
      ST_OFF:
        if (enable) begin
          next_state = ST_RAMP;
        end
      ST_RAMP, ST_ON:
        if (!enable) begin
          next_state = ST_OFF;
        end else if (any_fault) begin
          next_state = want_hiccup ? ST_HICCUP : ST_LATCH;
        end else if (state == ST_RAMP && RAMP_DONE) begin
          next_state = ST_ON;
        end
      ST_LATCH:
        if (clr_pulse || en_rise) begin
          next_state = enable ? ST_RAMP : ST_OFF;
        end
      ST_HICCUP:
        if (!enable) begin
          next_state = ST_OFF;
        end else if (hic_cnt == 32'h0000_0000) begin
          next_state = ST_RAMP;
        end
      default: next_state = ST_OFF;
    endcase
  end

  always @(posedge CLK) begin
    if (RST) begin
      state <= ST_OFF;
      en_q <= 1'b0;
      hic_cnt <= 32'h0000_0000;
      oc_cnt <= 5'h00;
      rc_cnt <= 5'h00;
      f_ov <= 1'b0;
      f_uv <= 1'b0;
      f_oc <= 1'b0;
      f_rc <= 1'b0;
      OUTPUT_RUN <= 1'b0;
    end else begin
      state <= next_state;
      en_q <= enable;
      OUTPUT_RUN <= (next_state == ST_RAMP) || (next_state == ST_ON);
      if (state == ST_ON && oc_now) begin
        oc_cnt <= (oc_cnt == `RFPPC_FILT_CYC) ? oc_cnt : oc_cnt + 5'h01;
      end else begin
        oc_cnt <= 5'h00;
      end
      if (state == ST_ON && rc_now) begin
        rc_cnt <= (rc_cnt == `RFPPC_FILT_CYC) ? rc_cnt : rc_cnt + 5'h01;
      end else begin
        rc_cnt <= 5'h00;
      end
      if (next_state == ST_HICCUP && state != ST_HICCUP) begin
        hic_cnt <= HICCUP_CYCLES - 1;
      end else if (state == ST_HICCUP && hic_cnt != 32'h0000_0000) begin
        hic_cnt <= hic_cnt - 32'h0000_0001;
      end
      // Sticky flags: a new fault wins over clear
      f_ov <= ov_det || (f_ov && !clr_pulse);
      f_uv <= uv_det || (f_uv && !clr_pulse);
      f_oc <= oc_det || (f_oc && !clr_pulse);
      f_rc <= rc_det || (f_rc && !clr_pulse);
    end
  end

  // Power-good tracking
  always @(posedge CLK) begin
    if (RST) begin
      pg <= 1'b0;
      pg_cnt <= 24'h000000;
    end else if (state != ST_ON || any_fault) begin
      pg <= 1'b0;
      pg_cnt <= 24'h000000;
    end else if (!pg) begin
      if (VOUT_PCT >= pg_on) begin
        if (pg_cnt >= pg_delay_cyc) begin
          pg <= 1'b1;
        end else begin
          pg_cnt <= pg_cnt + 24'h000001;
        end
      end else begin
        pg_cnt <= 24'h000000;
      end
    end else if (VOUT_PCT < pg_off) begin
      pg <= 1'b0;
      pg_cnt <= 24'h000000;
    end
  end

  // Pin drivers
  always @(posedge CLK) begin
    if (RST) begin
      POWER_GOOD_OUT <= 1'b0;
      POWER_GOOD_OE <= 1'b1;
      SYNC_OUT <= 1'b0;
      SYNC_OE <= 1'b0;
    end else begin
      POWER_GOOD_OUT <= ctrl[`RFPPC_CTRL_OD] ? 1'b0 : pg;
      POWER_GOOD_OE <= ctrl[`RFPPC_CTRL_OD] ? !pg : 1'b1;
      SYNC_OE <= (sync_mode == `RFPPC_SYNC_OUT);
      SYNC_OUT <= (sync_mode == `RFPPC_SYNC_OUT) &&
        (int_cnt < {1'b0, period[PERIOD_W-1:1]});
    end
  end

  // Internal reference and phase-delayed PWM trigger
  always @(posedge CLK) begin
    if (RST) begin
      int_cnt <= {PERIOD_W{1'b0}};
      ph_cnt <= {PERIOD_W{1'b0}};
      ph_run <= 1'b0;
      PWM_TRIGGER <= 1'b0;
    end else begin
      int_cnt <= int_edge ? {PERIOD_W{1'b0}} : int_cnt + 1'b1;
      PWM_TRIGGER <= 1'b0;
      if (ref_edge) begin
        ph_cnt <= {{(PERIOD_W-1){1'b0}}, 1'b1};
        ph_run <= (ph_off != {PERIOD_W{1'b0}});
        PWM_TRIGGER <= (ph_off == {PERIOD_W{1'b0}});
      end else if (ph_run) begin
        ph_cnt <= ph_cnt + 1'b1;
        if (ph_cnt == ph_off) begin
          PWM_TRIGGER <= 1'b1;
          ph_run <= 1'b0;
        end
      end
    end
  end

endmodule // rfppc_top
